// ---- shared/lpwe_pkg.sv ----
// package: constants, carriers and state codes of the local-to-pci write path
// Function
// R01: pci is always little-endian; local byte order bit selectable, big-endian after reset.
// R02: big-endian local bus swaps byte lanes, keeping each byte's address.
// R03: little-endian local bus keeps lanes, changing the address each lane represents.
// R04: byte-order setting applies to every channel of the device.
// R05: little-endian: data unchanged, enables from size and offset, e.g. byte at 00 gives 0111.
// R06: big-endian: lanes mirrored, enables mirrored; byte at 00 gives 1110, word at 01 gives 0001.
// R07: single writes posted when selected image's post enable set, else delayed; reset clear.
// R08: burst writes are always posted.
// R09: posted write acknowledged once queued; many may queue up to 256 bytes.
// R10: delayed write acknowledged after pci completion; one outstanding, other writes retried.
// R11: address entry holds address and command; data entry holds data and enables.
// R12: image attributes captured at queue time; reprogramming affects only later entries.
// R13: data beats are never merged in the outbound fifo.
// R14: write retried when fifo lacks room; single write needs two free entries.
// R15: pci bus requested only with a complete transaction queued.
// R16: no address phase deletion; each pci write as long as its local transaction.
// R17: burst is five entries, accepted only with room for five, never retried midway.
// R18: each 16-byte burst goes to pci with linear incrementing addresses.
// R19: bursts to i/o images or device registers end in bus error; master handles it.
// R20: posted-write speed-up bit reduces idle pci clocks between posted writes.
// R21: command from transaction type and space bit; i/o writes only for single cycles.
package lpwe_pkg;

   localparam logic [7:0] OFF_MISC_CONTROL = 8'h00;
   localparam logic [7:0] OFF_MISC_CONTROL_SECOND = 8'h04;
   localparam logic [7:0] OFF_IMAGE0_CTL = 8'h08;
   localparam logic [7:0] OFF_IMAGE1_CTL = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;

   localparam int BIT_BYTE_ORDER = 0;
   localparam int BIT_SPEEDUP = 0;
   localparam int BIT_POST_EN = 0;
   localparam int BIT_SPACE_IO = 1;
   localparam int BIT_DLY_PEND = 8;
   localparam int BIT_DLY_DONE = 9;
   localparam int BIT_LEVEL_LO = 16;

   localparam logic RST_BYTE_ORDER = 1'b1;
   localparam logic RST_SPEEDUP = 1'b0;
   localparam logic RST_POST_EN = 1'b0;
   localparam logic RST_SPACE_IO = 1'b0;

   localparam int FIFO_BYTES = 256;
   localparam int FIFO_ENTRIES = FIFO_BYTES / 4;
   localparam int SINGLE_ENTRIES = 2;
   localparam int BURST_ENTRIES = 5;
   localparam logic [1:0] BURST_LAST_BEAT = 2'h3;

   localparam logic [3:0] CMD_IO_WRITE = 4'h3;
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;

   localparam logic [1:0] GAP_SLOW = 2'h2;
   localparam logic [1:0] GAP_FAST = 2'h0;

   typedef enum logic [1:0] {L_IDLE, L_DATA, L_ANS} lpwe_lst_type;
   typedef enum logic [1:0] {P_IDLE, P_ADDR, P_DATA} lpwe_pst_type;

   typedef struct packed {
      logic valid;
      logic burst;
      logic reg_hit;
      logic [1:0] local_transfer_size;
      logic [31:0] pci_addr;
      logic [31:0] data;
   } lpwe_lcl_type;

   typedef struct packed {
      logic is_addr;
      logic last;
      logic delayed;
      logic [31:0] word;
      logic [3:0] tag;
   } lpwe_entry_type;

   typedef struct packed {
      logic addr_valid;
      logic data_valid;
      logic last;
      logic [31:0] ad;
      logic [3:0] cbe_n;
   } lpwe_pci_type;

endpackage

// ---- src/lpwe_write_path.sv ----
// local-to-pci write path: endian mapping, outbound write fifo and pci write master
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lpwe_write_path #(
   parameter int DEPTH = lpwe_pkg::FIFO_ENTRIES,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire lpwe_pkg::lpwe_lcl_type i_lcl,
   input wire logic i_image_select_input,
   output logic o_lcl_ack,
   output logic o_lcl_retry,
   output logic o_lcl_berr,
   output logic o_local_byte_order_select,
   output logic o_pci_req,
   input wire logic i_pci_gnt,
   input wire logic i_pci_trdy,
   output lpwe_pkg::lpwe_pci_type o_pci
);

   typedef struct packed {
      logic big;
      logic speed;
      logic [1:0] post;
      logic [1:0] io;
      lpwe_pkg::lpwe_lst_type lst;
      logic [1:0] beat;
      logic burst;
      logic delayed;
      logic ack;
      logic retry;
      logic berr;
      logic dly_pend;
      logic dly_done;
      logic [AW:0] count;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] txn;
      lpwe_pkg::lpwe_pst_type pst;
      logic [1:0] gap;
      logic cur_last;
      logic cur_dly;
      logic [31:0] prdata;
      lpwe_pkg::lpwe_pci_type pci;
   } lpwe_state_type;

   lpwe_state_type st_ff;
   lpwe_state_type nxt_st;
   lpwe_pkg::lpwe_entry_type mem_ff [DEPTH];
   lpwe_pkg::lpwe_entry_type head;
   lpwe_pkg::lpwe_entry_type push_entry;
   logic push;
   logic pop;
   logic finish;
   logic [AW:0] free;
   logic [2:0] nbytes;
   logic [3:0] lane_mask;
   logic [3:0] be_n;
   logic [31:0] lane_data;
   logic img_io;
   logic img_post;
   logic apb_wr;
   logic mapped;

   assign head = mem_ff[st_ff.rd];
   assign free = (AW + 1)'(DEPTH) - st_ff.count;
   assign img_io = st_ff.io[i_image_select_input];
   assign img_post = st_ff.post[i_image_select_input];

   // lanes from the addressed byte onward, clipped at the word end
   always_comb begin
      nbytes = (i_lcl.local_transfer_size == 2'h0) ? 3'h4 : {1'b0, i_lcl.local_transfer_size};
      lane_mask = (~(4'hf >> nbytes)) >> i_lcl.pci_addr[1:0];
      if (i_lcl.burst) begin
         lane_mask = 4'hf;
      end
      if (st_ff.big) begin
         be_n = ~{lane_mask[0], lane_mask[1], lane_mask[2], lane_mask[3]}; // [R06]
         lane_data = {i_lcl.data[7:0], i_lcl.data[15:8], i_lcl.data[23:16], i_lcl.data[31:24]}; // [R02]
      end else begin
         be_n = ~lane_mask; // [R05]
         lane_data = i_lcl.data; // [R03]
      end
   end

   assign apb_wr = i_psel && i_penable && i_pwrite;
   assign mapped = (i_paddr[7:0] <= lpwe_pkg::OFF_STATUS) && (i_paddr[1:0] == 2'h0) && (i_paddr[31:8] == 24'h0);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.retry = 1'b0;
      nxt_st.berr = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      finish = 1'b0;
      push_entry = '0;
      o_pci_req = 1'b0;

      // register access: read data is staged in the setup cycle, no wait states
      if (i_psel && !i_penable) begin
         nxt_st.prdata = 32'h0;
         unique case (i_paddr[7:0])
            lpwe_pkg::OFF_MISC_CONTROL: nxt_st.prdata[lpwe_pkg::BIT_BYTE_ORDER] = st_ff.big;
            lpwe_pkg::OFF_MISC_CONTROL_SECOND: nxt_st.prdata[lpwe_pkg::BIT_SPEEDUP] = st_ff.speed;
            lpwe_pkg::OFF_IMAGE0_CTL: nxt_st.prdata[1:0] = {st_ff.io[0], st_ff.post[0]};
            lpwe_pkg::OFF_IMAGE1_CTL: nxt_st.prdata[1:0] = {st_ff.io[1], st_ff.post[1]};
            lpwe_pkg::OFF_STATUS: begin
               nxt_st.prdata[lpwe_pkg::BIT_DLY_PEND] = st_ff.dly_pend;
               nxt_st.prdata[lpwe_pkg::BIT_DLY_DONE] = st_ff.dly_done;
               nxt_st.prdata[lpwe_pkg::BIT_LEVEL_LO +: AW + 1] = st_ff.count;
            end
            default: nxt_st.prdata = 32'h0;
         endcase
      end
      if (apb_wr && mapped) begin
         unique case (i_paddr[7:0])
            lpwe_pkg::OFF_MISC_CONTROL: nxt_st.big = i_pwdata[lpwe_pkg::BIT_BYTE_ORDER]; // [R01]
            lpwe_pkg::OFF_MISC_CONTROL_SECOND: nxt_st.speed = i_pwdata[lpwe_pkg::BIT_SPEEDUP];
            lpwe_pkg::OFF_IMAGE0_CTL: begin
               nxt_st.post[0] = i_pwdata[lpwe_pkg::BIT_POST_EN];
               nxt_st.io[0] = i_pwdata[lpwe_pkg::BIT_SPACE_IO];
            end
            lpwe_pkg::OFF_IMAGE1_CTL: begin
               nxt_st.post[1] = i_pwdata[lpwe_pkg::BIT_POST_EN];
               nxt_st.io[1] = i_pwdata[lpwe_pkg::BIT_SPACE_IO];
            end
            default: nxt_st.prdata = st_ff.prdata;
         endcase
      end

      // local slave side: one push per cycle, answers are one-cycle registered pulses
      unique case (st_ff.lst)
         lpwe_pkg::L_IDLE: begin
            if (i_lcl.valid) begin
               if (i_lcl.burst && (img_io || i_lcl.reg_hit)) begin
                  nxt_st.berr = 1'b1; // [R19]
                  nxt_st.lst = lpwe_pkg::L_ANS;
               end else if (i_lcl.reg_hit) begin
                  // single register accesses belong to the register block
                  nxt_st.lst = lpwe_pkg::L_IDLE;
               end else if (st_ff.dly_pend) begin
                  // the retried delayed write collects its completion here
                  if (st_ff.dly_done && !i_lcl.burst) begin
                     nxt_st.ack = 1'b1; // [R10]
                     nxt_st.dly_pend = 1'b0;
                     nxt_st.dly_done = 1'b0;
                  end else begin
                     nxt_st.retry = 1'b1; // [R10]
                  end
                  nxt_st.lst = lpwe_pkg::L_ANS;
               end else if (free < (AW + 1)'(i_lcl.burst ? lpwe_pkg::BURST_ENTRIES
                                                        : lpwe_pkg::SINGLE_ENTRIES)) begin
                  nxt_st.retry = 1'b1; // [R14] [R17]
                  nxt_st.lst = lpwe_pkg::L_ANS;
               end else begin
                  push = 1'b1;
                  push_entry.is_addr = 1'b1;
                  push_entry.delayed = !(i_lcl.burst || img_post); // [R07] [R08]
                  push_entry.word = i_lcl.pci_addr; // [R11]
                  push_entry.tag = img_io ? lpwe_pkg::CMD_IO_WRITE : lpwe_pkg::CMD_MEM_WRITE; // [R21] [R12]
                  nxt_st.burst = i_lcl.burst;
                  nxt_st.delayed = push_entry.delayed;
                  nxt_st.dly_pend = push_entry.delayed;
                  nxt_st.beat = 2'h0;
                  nxt_st.lst = lpwe_pkg::L_DATA;
               end
            end
         end
         lpwe_pkg::L_DATA: begin
            if (i_lcl.valid) begin
               // one entry per beat, never packed with a neighbour
               push = 1'b1; // [R13]
               push_entry.last = !st_ff.burst || (st_ff.beat == lpwe_pkg::BURST_LAST_BEAT);
               push_entry.delayed = st_ff.delayed;
               push_entry.word = lane_data; // [R11]
               push_entry.tag = be_n;
               nxt_st.ack = !st_ff.delayed; // [R09]
               nxt_st.retry = st_ff.delayed; // [R10]
               nxt_st.beat = st_ff.beat + 2'h1;
               nxt_st.lst = lpwe_pkg::L_ANS;
            end
         end
         lpwe_pkg::L_ANS: begin
            // beat wraps to zero after the fourth burst beat
            nxt_st.lst = (st_ff.burst && st_ff.beat != 2'h0) ? lpwe_pkg::L_DATA : lpwe_pkg::L_IDLE; // [R17]
         end
      endcase

      // pci write master
      unique case (st_ff.pst)
         lpwe_pkg::P_IDLE: begin
            if (st_ff.gap != 2'h0) begin
               nxt_st.gap = st_ff.gap - 2'h1;
            end else if (st_ff.txn != '0) begin
               o_pci_req = 1'b1; // [R15]
               if (i_pci_gnt) begin
                  pop = 1'b1;
                  nxt_st.pci = '0;
                  nxt_st.pci.addr_valid = 1'b1; // [R16]
                  nxt_st.pci.ad = head.word;
                  nxt_st.pci.cbe_n = head.tag;
                  nxt_st.cur_dly = head.delayed;
                  nxt_st.cur_last = 1'b0;
                  nxt_st.pst = lpwe_pkg::P_ADDR;
               end
            end
         end
         lpwe_pkg::P_ADDR, lpwe_pkg::P_DATA: begin
            if (i_pci_trdy) begin
               if (st_ff.pst == lpwe_pkg::P_DATA && st_ff.cur_last) begin
                  finish = 1'b1;
                  nxt_st.pci = '0;
                  if (st_ff.cur_dly) begin
                     nxt_st.dly_done = 1'b1;
                  end
                  nxt_st.gap = st_ff.speed ? lpwe_pkg::GAP_FAST : lpwe_pkg::GAP_SLOW; // [R20]
                  nxt_st.pst = lpwe_pkg::P_IDLE;
               end else begin
                  // data beats follow in order; the target increments the address linearly
                  pop = 1'b1; // [R18]
                  nxt_st.pci.addr_valid = 1'b0;
                  nxt_st.pci.data_valid = 1'b1;
                  nxt_st.pci.last = head.last;
                  nxt_st.pci.ad = head.word;
                  nxt_st.pci.cbe_n = head.tag;
                  nxt_st.cur_last = head.last;
                  nxt_st.pst = lpwe_pkg::P_DATA;
               end
            end
         end
         default: nxt_st.pst = lpwe_pkg::P_IDLE;
      endcase

      nxt_st.count = st_ff.count + (AW + 1)'(push) - (AW + 1)'(pop);
      nxt_st.txn = st_ff.txn + (AW + 1)'(push && push_entry.last) - (AW + 1)'(finish);
      if (push) begin
         nxt_st.wr = st_ff.wr + AW'(1);
      end
      if (pop) begin
         nxt_st.rd = st_ff.rd + AW'(1);
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         st_ff <= '0;
         st_ff.big <= lpwe_pkg::RST_BYTE_ORDER; // [R01]
         st_ff.speed <= lpwe_pkg::RST_SPEEDUP;
         st_ff.post <= {2{lpwe_pkg::RST_POST_EN}}; // [R07]
         st_ff.io <= {2{lpwe_pkg::RST_SPACE_IO}};
         st_ff.lst <= lpwe_pkg::L_IDLE;
         st_ff.pst <= lpwe_pkg::P_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // storage kept outside the state record: it needs no reset
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_ff[st_ff.wr] <= push_entry;
      end
   end

   assign o_prdata = st_ff.prdata;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped;
   assign o_lcl_ack = st_ff.ack;
   assign o_lcl_retry = st_ff.retry;
   assign o_lcl_berr = st_ff.berr;
   assign o_local_byte_order_select = st_ff.big; // [R04]
   assign o_pci = st_ff.pci;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   a_reset_big_endian: assert property ($past(i_reset) |-> st_ff.big) // [R01]
      else $error("byte order not big-endian after reset");
   a_le_byte_lane: assert property ((st_ff.lst == lpwe_pkg::L_DATA && !st_ff.big && !i_lcl.burst
      && i_lcl.local_transfer_size == 2'h1 && i_lcl.pci_addr[1:0] == 2'h0) |-> be_n == 4'h7) // [R05]
      else $error("little-endian byte at offset 0 has wrong enables");
   a_be_word_off: assert property ((st_ff.big && !i_lcl.burst && i_lcl.local_transfer_size == 2'h0
      && i_lcl.pci_addr[1:0] == 2'h1) |-> be_n == 4'h1) // [R06]
      else $error("big-endian word at offset 1 has wrong enables");
   a_be_lane_swap: assert property ((push && !push_entry.is_addr && st_ff.big)
      |-> push_entry.word == {i_lcl.data[7:0], i_lcl.data[15:8], i_lcl.data[23:16], i_lcl.data[31:24]}) // [R02]
      else $error("big-endian data not lane swapped");
   a_delayed_retry: assert property ((st_ff.lst == lpwe_pkg::L_IDLE && i_lcl.valid && st_ff.dly_pend
      && !st_ff.dly_done
      && !i_lcl.reg_hit && !(i_lcl.burst && img_io)) |=> o_lcl_retry && !o_lcl_ack) // [R10]
      else $error("write not retried while delayed write outstanding");
   a_room_retry: assert property ((st_ff.lst == lpwe_pkg::L_IDLE && i_lcl.valid && !st_ff.dly_pend
      && !i_lcl.burst
      && !i_lcl.reg_hit && free < (AW + 1)'(2)) |=> o_lcl_retry ##1 !o_lcl_ack) // [R14]
      else $error("single write taken without two free entries");
   a_burst_error: assert property ((st_ff.lst == lpwe_pkg::L_IDLE && i_lcl.valid && i_lcl.burst
      && (i_lcl.reg_hit || img_io)) |=> o_lcl_berr && !o_lcl_ack && !$past(push)) // [R19]
      else $error("bad burst not ended with bus error");
   a_burst_no_retry: assert property ((st_ff.lst == lpwe_pkg::L_DATA && st_ff.burst) |=> !o_lcl_retry[*2]) // [R17]
      else $error("burst retried in progress");
   a_req_complete: assert property (o_pci_req |-> st_ff.txn != '0 && st_ff.count >= (AW + 1)'(2)) // [R15]
      else $error("pci requested without complete transaction");
   a_posted_ack: assert property ((st_ff.lst == lpwe_pkg::L_DATA && i_lcl.valid && !st_ff.delayed)
      |=> o_lcl_ack && st_ff.count != '0) // [R09]
      else $error("posted write not acknowledged when queued");
   a_slow_gap: assert property ((finish && !st_ff.speed) |=> !o_pci_req[*2]) // [R20]
      else $error("idle gap missing between posted writes");

endmodule
`default_nettype wire

// ---- testbench/lpwe_pci_target.sv ----
// pci arbiter and target model facing the write path's pci master
`timescale 1ns/1ps
`default_nettype none
module lpwe_pci_target (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_hold,
   input wire logic i_slow,
   input wire logic i_req,
   input wire lpwe_pkg::lpwe_pci_type i_pci,
   output logic o_gnt,
   output logic o_trdy
);
   // hold withholds grant so the bench can stack entries behind a stalled bus
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_gnt <= 1'b0;
         o_trdy <= 1'b0;
      end else begin
         o_gnt <= i_req && !i_hold && (!i_slow || $urandom_range(1) == 1);
         // trdy follows a phase the master showed one cycle earlier, so it can stay high one idle cycle past the last phase
         o_trdy <= (i_pci.addr_valid || i_pci.data_valid) && (!i_slow || $urandom_range(1) == 1);
      end
   end
endmodule
`default_nettype wire

// ---- testbench/lpwe_write_path_bench.sv ----
// self-checking bench of the local-to-pci write path against a queue model
`timescale 1ns/1ps
`default_nettype none
module lpwe_write_path_bench;
   localparam int DEPTH = 16;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0, slow = 1'b0, image_select_input = 1'b0, er, gap_on = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, d, a;
   logic pready, pslverr, ack, retry, berr, order_sel, req, gnt, trdy;
   logic [1:0] res;
   lpwe_pkg::lpwe_lcl_type lcl = '0;
   lpwe_pkg::lpwe_pci_type pci;
   lpwe_pkg::lpwe_pci_type exp_q[$];
   logic [31:0] mask_q[$];
   int bad_count = 0, num_checks = 0, gap = 0, last_gap = -1;
   int rst_val[5] = '{1, 0, 0, 0, 0};
   int f_bst[7] = '{0, 0, 1, 1, 1, 0, 0};
   int f_res[7] = '{1, 1, 1, 1, 2, 1, 2};

   always #20 i_clock = ~i_clock;

   lpwe_write_path #(.DEPTH(DEPTH)) lpwe_write_path_inst (.i_clock(i_clock), .i_reset(i_reset), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_lcl(lcl), .i_image_select_input(image_select_input), .o_lcl_ack(ack),
      .o_lcl_retry(retry), .o_lcl_berr(berr), .o_local_byte_order_select(order_sel), .o_pci_req(req),
      .i_pci_gnt(gnt), .i_pci_trdy(trdy), .o_pci(pci));
   lpwe_pci_target lpwe_pci_target_inst (.i_clock(i_clock), .i_reset(i_reset), .i_hold(hold), .i_slow(slow),
      .i_req(req), .i_pci(pci), .o_gnt(gnt), .o_trdy(trdy));

   task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic summarize();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge i_clock);
      penable <= 1'b1;
      // only the watchdog bounds this wait
      do begin
         @(posedge i_clock);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic lw(input logic bst, input logic rh, input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] dd);
      int n;
      int beat;
      logic quiet;
      quiet = (exp_q.size() == 0);
      lcl <= '{valid: 1'b1, burst: bst, reg_hit: rh, local_transfer_size: sz, pci_addr: ad, data: dd};
      beat = 0;
      n = 0;
      res = 2'd0;
      while (res == 2'd0 && n < 40) begin
         @(posedge i_clock);
         n++;
         if (bst && quiet && beat < 3) check("req_mid_burst", 0, req);
         if (ack === 1'b1 && bst && beat < 3) begin
            beat++;
            lcl.data <= dd + beat;
         end else if (ack === 1'b1) res = 2'd1;
         else if (retry === 1'b1) res = 2'd2;
         else if (berr === 1'b1) res = 2'd3;
      end
      lcl.valid <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic push(input logic io, input logic big, input logic bst, input logic [1:0] sz);
      lpwe_pkg::lpwe_pci_type p;
      logic [3:0] be;
      logic [31:0] dd;
      int n;
      p = '0;
      p.addr_valid = 1'b1;
      p.ad = a;
      p.cbe_n = io ? lpwe_pkg::CMD_IO_WRITE : lpwe_pkg::CMD_MEM_WRITE;
      exp_q.push_back(p);
      mask_q.push_back(32'hffffffff);
      n = (sz == 2'd0) ? 4 : int'(sz);
      be = 4'hf;
      for (int k = a[1:0]; k < a[1:0] + n && k < 4; k++) be[3 - k] = 1'b0;
      for (int b = 0; b < (bst ? 4 : 1); b++) begin
         dd = d + b;
         p = '0;
         p.data_valid = 1'b1;
         p.last = (b == (bst ? 3 : 0));
         p.ad = big ? {dd[7:0], dd[15:8], dd[23:16], dd[31:24]} : dd;
         p.cbe_n = big ? {be[0], be[1], be[2], be[3]} : be;
         exp_q.push_back(p);
         mask_q.push_back({{8{~p.cbe_n[3]}}, {8{~p.cbe_n[2]}}, {8{~p.cbe_n[1]}}, {8{~p.cbe_n[0]}}});
      end
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() > 0 && n < 3000) begin
         @(posedge i_clock);
         n++;
      end
      check("pci_drained", 0, exp_q.size());
      repeat (4) @(posedge i_clock);
   endtask

   always @(posedge i_clock) begin
      if (gap_on && req === 1'b1) begin
         last_gap = gap;
         gap_on = 1'b0;
      end else if (gap_on) gap++;
      if (!i_reset && trdy === 1'b1 && (pci.addr_valid === 1'b1 || pci.data_valid === 1'b1)) begin
         if (exp_q.size() == 0) begin
            check("pci_extra_phase", 0, 1);
         end else begin
            check("pci_phase", {exp_q[0].addr_valid, exp_q[0].last, exp_q[0].cbe_n},
               {pci.addr_valid, pci.last, pci.cbe_n});
            check("pci_ad", exp_q[0].ad & mask_q[0], pci.ad & mask_q[0]);
            void'(exp_q.pop_front());
            void'(mask_q.pop_front());
         end
         if (pci.last === 1'b1) begin
            gap_on = 1'b1;
            gap = 0;
         end
      end
   end

   initial begin
      repeat (60000) @(posedge i_clock);
      bad_count++;
      summarize();
   end

   initial begin
      void'($urandom(32'h9e50));
      repeat (12) @(posedge i_clock);
      i_reset <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, i * 4, 32'h0);
         check("reg_reset", rst_val[i], rd);
      end
      check("order_out_reset", 1, order_sel);
      apb(1'b0, 32'h14, 32'h0);
      check("unmapped_err", 1, er);
      apb(1'b1, 32'h08, 32'h1);
      for (int big = 0; big < 2; big++) begin
         apb(1'b1, 32'h00, big);
         check("order_out", big, order_sel);
         for (int i = 0; i < 16; i++) begin
            d = $urandom;
            a = ($urandom & 32'hfffffffc) | (i % 4);
            lw(1'b0, 1'b0, 2'(i / 4), a, d);
            check("posted_ack", 1, res);
            push(1'b0, big[0], 1'b0, 2'(i / 4));
         end
         drain();
      end
      image_select_input <= 1'b1;
      hold <= 1'b1;
      d = $urandom;
      a = $urandom & 32'hfffffffc;
      lw(1'b0, 1'b0, 2'd0, a, d);
      check("delayed_first", 2, res);
      push(1'b0, 1'b1, 1'b0, 2'd0);
      lw(1'b0, 1'b0, 2'd0, a + 4, ~d);
      check("delayed_other", 2, res);
      apb(1'b0, 32'h10, 32'h0);
      check("delayed_pending", 1, rd[8]);
      hold <= 1'b0;
      drain();
      lw(1'b0, 1'b0, 2'd0, a, d);
      check("delayed_done", 1, res);
      d = $urandom;
      a = $urandom & 32'hfffffff0;
      lw(1'b1, 1'b0, 2'd0, a, d);
      check("burst_posted", 1, res);
      push(1'b0, 1'b1, 1'b1, 2'd0);
      drain();
      image_select_input <= 1'b0;
      hold <= 1'b1;
      for (int t = 0; t < 2; t++) begin
         d = $urandom;
         a = $urandom & 32'hfffffffc;
         lw(1'b0, 1'b0, 2'd0, a, d);
         check("attr_ack", 1, res);
         push(t[0], 1'b1, 1'b0, 2'd0);
         apb(1'b1, 32'h08, 32'h3);
      end
      hold <= 1'b0;
      drain();
      for (int t = 0; t < 2; t++) begin
         apb(1'b1, 32'h08, t ? 32'h1 : 32'h3);
         lw(1'b1, t[0], 2'd0, a & 32'hfffffff0, d);
         check("burst_berr", 3, res);
      end
      hold <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         d = $urandom;
         a = $urandom & 32'hfffffff0;
         lw(f_bst[i][0], 1'b0, 2'd0, a, d);
         check("fifo_room", f_res[i], res);
         if (res == 2'd1) push(1'b0, 1'b1, f_bst[i][0], 2'd0);
      end
      slow <= 1'b1;
      hold <= 1'b0;
      drain();
      slow <= 1'b0;
      for (int sp = 0; sp < 2; sp++) begin
         apb(1'b1, 32'h04, sp);
         hold <= 1'b1;
         for (int t = 0; t < 2; t++) begin
            d = $urandom;
            a = $urandom & 32'hfffffffc;
            lw(1'b0, 1'b0, 2'd0, a, d);
            push(1'b0, 1'b1, 1'b0, 2'd0);
         end
         hold <= 1'b0;
         drain();
         check("idle_gap", sp ? lpwe_pkg::GAP_FAST : lpwe_pkg::GAP_SLOW, last_gap);
      end
      summarize();
   end
endmodule
`default_nettype wire
